/* File: design/smon_status_monitor.sv */
// vitals monitor: status pins, interrupt and registers
//
// Overview of operation
// [R1] two selects map any vital to each pin
// [R2] polarity register inverts each pin's event
// [R3] codes 0,1,2,5 pick reference and lock vitals
// [R4] codes 3,4,6,7,11,12 pick halved dividers
// [R5] codes 8-10,13-15 pick cal, irq, eeprom load busy, switches
// [R6] interrupt active high, only when enable set
// [R7] control bit 1 picks and or or
// [R8] mask bits drop vitals from the interrupt
// [R9] latched status clears after read
// [R10] live status ignores enable, clears after read
// [R11] swing thresholds per reference
// [R12] lvcmos loss also checks slow edges
// [R13] every single cycle slip is counted
// [R14] unlock past slip limit, then counter resets
// [R15] each pin carries its own pll clock
// [R16] clock pins optionally mute static on unlock
// [R17] slew register slows status pin edges
// [R18] writes to read-only bits change nothing
// [R19] host keeps reserved bits at reset values
// [R20] power-up loads eeprom or rom per pin
// [R21] host limits eeprom rewrites, rom is fixed
// [R22] first register transaction after power-up ignored; code drops every host access until the copy is done
// [R23] latched bit holds until its clearing read; code also clears it while enable is low
`default_nettype none
module smon_status_monitor #(
    parameter int SLIPS = smon_pkg::SLIP_LIMIT,
    parameter int RELOCK = smon_pkg::RELOCK_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire smon_pkg::smon_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    input wire logic config_source_pin,
    output logic nvm_load_req,
    output logic nvm_from_eeprom,
    input wire smon_pkg::smon_req_t nvm_req,
    input wire logic nvm_load_done,
    input wire smon_pkg::smon_ref_t main_reference,
    input wire smon_pkg::smon_ref_t backup_reference,
    output logic [1:0] main_los_threshold,
    output logic [1:0] backup_los_threshold,
    input wire logic [1:0] pll_cmp_tick,
    input wire logic [1:0] pll_slip,
    input wire logic [1:0] pll_cal_active,
    input wire logic [1:0] pll_auto_switch,
    input wire logic [5:0] div_tick,
    input wire logic [1:0] r_div_bypass,
    input wire logic [1:0] m_div_bypass,
    output logic vital_pin_a,
    output logic vital_pin_b,
    output logic [1:0] pin_slow_slew,
    output logic combined_irq
);
    ////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] irq_mask_ff;
    logic [7:0] pin_polarity_ff;
    logic [7:0] interrupt_control_ff;
    logic [7:0] pin_clock_mute_enable_ff;
    logic [7:0] loss_of_signal_config_ff;
    logic [3:0] pin_select_a_ff;
    logic [3:0] pin_select_b_ff;
    logic [7:0] pin_slew_control_ff;
    logic [7:0] live_irq_status_ff;
    logic [7:0] latched_irq_status_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [7:0] vital_prev_ff;
    logic [5:0] half_ff;
    logic pin_a_ff;
    logic pin_b_ff;
    logic [1:0] slew_ff;
    logic irq_ff;
    logic src_ff;
    smon_pkg::smon_load_t load_ff;
    smon_pkg::smon_load_t nxt_load;

    ////////////////////////////////////////////////////////////////////
    // helper functions

    // pll of a divider code: 0 none, 1 pll1, 2 pll2
    function automatic logic [1:0] pll_of_code(input logic [3:0] code);
        case (code)
            smon_pkg::VIT_PLL1_R, smon_pkg::VIT_PLL1_N,
            smon_pkg::VIT_PLL1_M: pll_of_code = 2'b01;
            smon_pkg::VIT_PLL2_R, smon_pkg::VIT_PLL2_N,
            smon_pkg::VIT_PLL2_M: pll_of_code = 2'b10;
            default: pll_of_code = 2'b00;
        endcase
    endfunction

    // loss of signal from front-end flags
    function automatic logic ref_missing(input smon_pkg::smon_ref_t r,
                                         input logic [1:0] edge_sel);
        logic slow_edge;
        slow_edge = (edge_sel[0] && r.slow_rise) || (edge_sel[1] && r.slow_fall);
        ref_missing = r.swing_low || (r.is_lvcmos && slow_edge);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // power-up configuration load

    logic loading;
    logic wr_any;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    // loader owns the write path during the copy,
    // so host writes cannot race it
    assign loading = (load_ff != smon_pkg::LD_DONE); // [R22]
    assign wr_any = loading ? nvm_req.wr : host_req.wr;
    assign wr_addr = loading ? nvm_req.addr : host_req.addr;
    assign wr_data = loading ? nvm_req.wdata : host_req.wdata;
    assign nvm_load_req = (load_ff == smon_pkg::LD_REQ);
    assign nvm_from_eeprom = src_ff;

    // sequencer: request the copy, wait for done
    always_comb begin
        case (load_ff)
            smon_pkg::LD_IDLE: nxt_load = smon_pkg::LD_REQ;
            smon_pkg::LD_REQ: nxt_load = smon_pkg::LD_BUSY;
            smon_pkg::LD_BUSY: nxt_load = nvm_load_done ? smon_pkg::LD_DONE
                                                        : smon_pkg::LD_BUSY;
            smon_pkg::LD_DONE: nxt_load = smon_pkg::LD_DONE;
            default: nxt_load = smon_pkg::LD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_ff <= smon_pkg::LD_IDLE;
        end else begin
            load_ff <= nxt_load; // [R20]
        end
    end

    // source pin sampled once after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_ff <= 1'b0;
        end else if (load_ff == smon_pkg::LD_IDLE) begin
            src_ff <= config_source_pin; // [R20]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // writable registers

    logic wr_mask, wr_pol, wr_ctrl, wr_mute, wr_los, wr_sel_a, wr_sel_b;
    logic wr_slew;

    // status registers have no write strobe
    assign wr_mask = wr_any && (wr_addr == smon_pkg::ADR_IRQ_MASK);
    assign wr_pol = wr_any && (wr_addr == smon_pkg::ADR_PIN_POL);
    assign wr_ctrl = wr_any && (wr_addr == smon_pkg::ADR_IRQ_CTRL);
    assign wr_mute = wr_any && (wr_addr == smon_pkg::ADR_MUTE_EN);
    assign wr_los = wr_any && (wr_addr == smon_pkg::ADR_LOS_CFG);
    assign wr_sel_a = wr_any && (wr_addr == smon_pkg::ADR_PIN_SEL_A);
    assign wr_sel_b = wr_any && (wr_addr == smon_pkg::ADR_PIN_SEL_B);
    assign wr_slew = wr_any && (wr_addr == smon_pkg::ADR_SLEW_CTRL);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_ff <= smon_pkg::RST_IRQ_MASK;
            pin_polarity_ff <= smon_pkg::RST_PIN_POL;
            interrupt_control_ff <= smon_pkg::RST_IRQ_CTRL;
            pin_clock_mute_enable_ff <= smon_pkg::RST_MUTE_EN;
        end else begin
            if (wr_mask) irq_mask_ff <= wr_data;
            if (wr_pol) pin_polarity_ff <= wr_data;
            // bits 7:2 do not exist and read zero
            if (wr_ctrl) interrupt_control_ff <= {6'h00, wr_data[1:0]}; // [R18]
            if (wr_mute) pin_clock_mute_enable_ff <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loss_of_signal_config_ff <= smon_pkg::RST_LOS_CFG;
            pin_select_a_ff <= smon_pkg::RST_PIN_SEL_A;
            pin_select_b_ff <= smon_pkg::RST_PIN_SEL_B;
            pin_slew_control_ff <= smon_pkg::RST_SLEW_CTRL;
        end else begin
            if (wr_los) loss_of_signal_config_ff <= wr_data;
            if (wr_sel_a) pin_select_a_ff <= wr_data[3:0];
            if (wr_sel_b) pin_select_b_ff <= wr_data[3:0];
            if (wr_slew) pin_slew_control_ff <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // vitals

    logic main_missing, backup_missing;
    logic [1:0] lock_lost;
    logic [7:0] vitals;
    logic irq_en, and_mode;

    // thresholds feed the analog comparators
    assign main_los_threshold =
        loss_of_signal_config_ff[smon_pkg::LOS_MAIN_THR +: 2]; // [R11]
    assign backup_los_threshold =
        loss_of_signal_config_ff[smon_pkg::LOS_BACKUP_THR +: 2]; // [R11]
    assign main_missing = ref_missing(main_reference,
        loss_of_signal_config_ff[smon_pkg::LOS_MAIN_EDGE +: 2]); // [R12]
    assign backup_missing = ref_missing(backup_reference,
        loss_of_signal_config_ff[smon_pkg::LOS_BACKUP_EDGE +: 2]); // [R12]

    // one slip detector per pll
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_lock
            smon_lock_det #(.SLIPS(SLIPS), .RELOCK(RELOCK)) u_det (
                .clk(clk),
                .rst_n(rst_n),
                .cmp_tick(pll_cmp_tick[gp]),
                .slip(pll_slip[gp]),
                .lock_lost(lock_lost[gp]) // [R13]
            );
        end
    endgenerate

    // order r1 n1 m1 r2 n2 m2; a tick toggles the half-rate copy
    generate
        for (gp = 0; gp < 6; gp++) begin : g_half
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    half_ff[gp] <= 1'b0;
                end else if (div_tick[gp]) begin
                    half_ff[gp] <= ~half_ff[gp]; // [R4]
                end
            end
        end
    endgenerate

    // interrupt sources in status bit order
    assign vitals[smon_pkg::IRQ_MAIN_LOS] = main_missing;
    assign vitals[smon_pkg::IRQ_BACKUP_LOS] = backup_missing;
    assign vitals[smon_pkg::IRQ_PLL1_LOL] = lock_lost[0];
    assign vitals[smon_pkg::IRQ_PLL2_LOL] = lock_lost[1];
    assign vitals[smon_pkg::IRQ_PLL1_CAL] = pll_cal_active[0];
    assign vitals[smon_pkg::IRQ_PLL2_CAL] = pll_cal_active[1];
    assign vitals[smon_pkg::IRQ_PLL1_SW] = pll_auto_switch[0];
    assign vitals[smon_pkg::IRQ_PLL2_SW] = pll_auto_switch[1];

    ////////////////////////////////////////////////////////////////////
    // interrupt status and combine

    logic rd_live, rd_latched;
    logic [7:0] rise;
    logic [7:0] unmasked;
    logic irq_and, irq_or, nxt_irq;

    assign irq_en = interrupt_control_ff[smon_pkg::CTRL_IRQ_EN];
    assign and_mode = interrupt_control_ff[smon_pkg::CTRL_AND_MODE];
    // a read completes in its request cycle
    assign rd_live = host_req.rd && !loading &&
                     (host_req.addr == smon_pkg::ADR_LIVE_IRQ);
    assign rd_latched = host_req.rd && !loading &&
                        (host_req.addr == smon_pkg::ADR_LATCHED_IRQ);
    assign rise = vitals & ~vital_prev_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vital_prev_ff <= 8'h00;
        end else begin
            vital_prev_ff <= vitals;
        end
    end

    // live bits ignore enable; an active vital
    // re-sets its bit on a clearing read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_irq_status_ff <= 8'h00;
        end else if (rd_live) begin
            live_irq_status_ff <= vitals; // [R10]
        end else begin
            live_irq_status_ff <= live_irq_status_ff | vitals; // [R10]
        end
    end

    // latched bits catch rises only while enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_irq_status_ff <= 8'h00;
        end else if (!irq_en) begin
            latched_irq_status_ff <= 8'h00; // [R9]
        end else if (rd_latched) begin
            latched_irq_status_ff <= rise; // [R9]
        end else begin
            latched_irq_status_ff <= latched_irq_status_ff | rise; // [R23]
        end
    end

    // and-mode with all masked stays low
    assign unmasked = ~irq_mask_ff; // [R8]
    assign irq_or = |(latched_irq_status_ff & unmasked); // [R7]
    assign irq_and = (|unmasked) &&
                     (&(latched_irq_status_ff | irq_mask_ff)); // [R7]
    assign nxt_irq = irq_en && (and_mode ? irq_and : irq_or); // [R6]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq; // [R6]
        end
    end

    assign combined_irq = irq_ff;

    ////////////////////////////////////////////////////////////////////
    // status pin selection

    logic [15:0] table_sel;
    logic [1:0] src_a, src_b;
    logic mute_a, mute_b, nxt_pin_a, nxt_pin_b;

    // index is the code; bypassed dividers read low
    assign table_sel = {
        pll_auto_switch[1], pll_auto_switch[0], // [R5]
        loading && src_ff, // [R5]
        half_ff[5] && !m_div_bypass[1], half_ff[2] && !m_div_bypass[0], // [R4]
        irq_ff, pll_cal_active[1], pll_cal_active[0], // [R5]
        half_ff[4], half_ff[3] && !r_div_bypass[1], // [R4]
        lock_lost[1], // [R3]
        half_ff[1], half_ff[0] && !r_div_bypass[0], // [R4]
        lock_lost[0], backup_missing, main_missing // [R3]
    };

    assign src_a = pll_of_code(pin_select_a_ff);
    assign src_b = pll_of_code(pin_select_b_ff);
    // mute a pll clock pin when that pll loses lock
    assign mute_a = pin_clock_mute_enable_ff[smon_pkg::PIN_A] &&
                    |(src_a & lock_lost); // [R16]
    assign mute_b = pin_clock_mute_enable_ff[smon_pkg::PIN_B] &&
                    |(src_b & lock_lost); // [R16]
    // a muted pin rests at its polarity level
    assign nxt_pin_a = (mute_a ? 1'b0 : table_sel[pin_select_a_ff]) ^
                       pin_polarity_ff[smon_pkg::PIN_A]; // [R1] [R2] [R15]
    assign nxt_pin_b = (mute_b ? 1'b0 : table_sel[pin_select_b_ff]) ^
                       pin_polarity_ff[smon_pkg::PIN_B]; // [R1] [R2] [R15]

    // pins are retimed on this clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a_ff <= 1'b0;
            pin_b_ff <= 1'b0;
            slew_ff <= 2'b00;
        end else begin
            pin_a_ff <= nxt_pin_a;
            pin_b_ff <= nxt_pin_b;
            slew_ff <= pin_slew_control_ff[1:0]; // [R17]
        end
    end

    assign vital_pin_a = pin_a_ff;
    assign vital_pin_b = pin_b_ff;
    assign pin_slow_slew = slew_ff;

    ////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] nxt_rdata;

    // unmapped addresses read zero
    always_comb begin
        case (host_req.addr)
            smon_pkg::ADR_LIVE_IRQ: nxt_rdata = live_irq_status_ff;
            smon_pkg::ADR_IRQ_MASK: nxt_rdata = irq_mask_ff;
            smon_pkg::ADR_PIN_POL: nxt_rdata = pin_polarity_ff;
            smon_pkg::ADR_LATCHED_IRQ: nxt_rdata = latched_irq_status_ff;
            smon_pkg::ADR_IRQ_CTRL: nxt_rdata = interrupt_control_ff;
            smon_pkg::ADR_MUTE_EN: nxt_rdata = pin_clock_mute_enable_ff;
            smon_pkg::ADR_LOS_CFG: nxt_rdata = loss_of_signal_config_ff;
            smon_pkg::ADR_PIN_SEL_A: nxt_rdata = {4'h0, pin_select_a_ff};
            smon_pkg::ADR_PIN_SEL_B: nxt_rdata = {4'h0, pin_select_b_ff};
            smon_pkg::ADR_SLEW_CTRL: nxt_rdata = pin_slew_control_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= host_req.rd && !loading;
            if (host_req.rd && !loading) rdata_ff <= nxt_rdata; // [R1]
        end
    end

    assign host_rdata = rdata_ff;
    assign host_rvalid = rvalid_ff;
endmodule
`default_nettype wire

/* File: include/smon_pkg.sv */
// constants and types of the status monitor
`default_nettype none
package smon_pkg;
    // register byte addresses
    localparam logic [7:0] ADR_LIVE_IRQ = 8'h0d;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h0e;
    localparam logic [7:0] ADR_PIN_POL = 8'h0f;
    localparam logic [7:0] ADR_LATCHED_IRQ = 8'h10;
    localparam logic [7:0] ADR_IRQ_CTRL = 8'h11;
    localparam logic [7:0] ADR_MUTE_EN = 8'h17;
    localparam logic [7:0] ADR_LOS_CFG = 8'h19;
    localparam logic [7:0] ADR_PIN_SEL_A = 8'h1b;
    localparam logic [7:0] ADR_PIN_SEL_B = 8'h1c;
    localparam logic [7:0] ADR_SLEW_CTRL = 8'h31;
    // reset values
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    localparam logic [7:0] RST_PIN_POL = 8'h00;
    localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
    localparam logic [7:0] RST_MUTE_EN = 8'h00;
    localparam logic [7:0] RST_LOS_CFG = 8'h00;
    localparam logic [3:0] RST_PIN_SEL_A = 4'h0;
    localparam logic [3:0] RST_PIN_SEL_B = 4'h2;
    localparam logic [7:0] RST_SLEW_CTRL = 8'h00;
    // field positions
    localparam int CTRL_IRQ_EN = 0;
    localparam int CTRL_AND_MODE = 1;
    localparam int LOS_MAIN_THR = 0;
    localparam int LOS_BACKUP_THR = 2;
    localparam int LOS_MAIN_EDGE = 4;
    localparam int LOS_BACKUP_EDGE = 6;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    // interrupt source bits in live, latched and mask
    localparam int IRQ_MAIN_LOS = 0;
    localparam int IRQ_BACKUP_LOS = 1;
    localparam int IRQ_PLL1_LOL = 2;
    localparam int IRQ_PLL2_LOL = 3;
    localparam int IRQ_PLL1_CAL = 4;
    localparam int IRQ_PLL2_CAL = 5;
    localparam int IRQ_PLL1_SW = 6;
    localparam int IRQ_PLL2_SW = 7;
    // lock detector defaults
    localparam int SLIP_LIMIT = 4;
    localparam int RELOCK_TICKS = 16;
    // vital selection codes
    typedef enum logic [3:0] {
        VIT_MAIN_LOS = 4'h0, VIT_BACKUP_LOS = 4'h1, VIT_PLL1_LOL = 4'h2,
        VIT_PLL1_R = 4'h3, VIT_PLL1_N = 4'h4, VIT_PLL2_LOL = 4'h5,
        VIT_PLL2_R = 4'h6, VIT_PLL2_N = 4'h7, VIT_PLL1_CAL = 4'h8,
        VIT_PLL2_CAL = 4'h9, VIT_IRQ = 4'ha, VIT_PLL1_M = 4'hb,
        VIT_PLL2_M = 4'hc, VIT_NVM_BUSY = 4'hd, VIT_PLL1_SW = 4'he,
        VIT_PLL2_SW = 4'hf
    } smon_vital_t;
    // power-up load sequencer states
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00, LD_REQ = 2'b01, LD_BUSY = 2'b10, LD_DONE = 2'b11
    } smon_load_t;
    // front-end flags of one reference
    typedef struct packed {
        logic is_lvcmos;
        logic swing_low;
        logic slow_rise;
        logic slow_fall;
    } smon_ref_t;
    // one register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smon_req_t;
endpackage
`default_nettype wire

/* File: design/smon_lock_det.sv */
// digital cycle-slip lock detector for one pll
`default_nettype none
module smon_lock_det #(
    parameter int SLIPS = smon_pkg::SLIP_LIMIT,
    parameter int RELOCK = smon_pkg::RELOCK_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmp_tick,
    input wire logic slip,
    output logic lock_lost
);
    logic [7:0] slip_cnt_ff;
    logic [7:0] clean_cnt_ff;
    logic lost_ff;
    logic over_limit;
    logic relocked;

    // unlock on the slip past the limit
    assign over_limit = slip && (slip_cnt_ff >= 8'(SLIPS)); // [R14]
    assign relocked = cmp_tick && !slip && (clean_cnt_ff == 8'(RELOCK - 1));
    assign lock_lost = lost_ff;

    // every slip counts; restart on unlock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slip_cnt_ff <= 8'h00;
        end else if (over_limit) begin
            slip_cnt_ff <= 8'h00; // [R14]
        end else if (slip) begin
            slip_cnt_ff <= slip_cnt_ff + 8'h01; // [R13]
        end
    end

    // clean comparisons in a row reclaim lock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clean_cnt_ff <= 8'h00;
        end else if (slip || relocked) begin
            clean_cnt_ff <= 8'h00;
        end else if (cmp_tick) begin
            clean_cnt_ff <= clean_cnt_ff + 8'h01;
        end
    end

    // unlock wins over a relock landing in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lost_ff <= 1'b0;
        end else if (over_limit) begin
            lost_ff <= 1'b1; // [R14]
        end else if (relocked) begin
            lost_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/smon_status_monitor_monitor.sv */
// concurrent checks on the register port and loader handshake
`default_nettype none
module smon_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire smon_pkg::smon_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid,
    input wire logic nvm_load_req,
    input wire logic nvm_load_done,
    input wire logic [1:0] main_los_threshold,
    input wire logic [1:0] backup_los_threshold,
    input wire logic [1:0] pin_slow_slew
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_ff;
    logic ready_ff;
    wire logic wr_go = ready_ff & host_req.wr;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // mirror the copy; requests during it are not taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            busy_ff <= busy_ff | nvm_load_req;
            ready_ff <= ready_ff | (busy_ff & nvm_load_done);
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_rd_answer: assert property (ready_ff && host_req.rd |=> host_rvalid)
        else $error("read not answered");
    chk_rv_cause: assert property (host_rvalid |-> $past(host_req.rd && ready_ff))
        else $error("answer without read");
    chk_rdata_hold: assert property (!host_rvalid |-> $stable(host_rdata))
        else $error("read data moved");
    chk_load_pulse: assert property (nvm_load_req |=> !nvm_load_req)
        else $error("load request too long");
    chk_ctrl_zero: assert property (host_rvalid && $past(host_req.addr) == 8'h11
        |-> host_rdata[7:2] == 6'h00) else $error("control spare bits set");
    chk_sel_zero: assert property (host_rvalid && $past(host_req.addr) == 8'h1c
        |-> host_rdata[7:4] == 4'h0) else $error("select spare bits set");
    chk_slew_write: assert property (wr_go && host_req.addr == 8'h31
        |-> ##2 pin_slow_slew == $past(host_req.wdata[1:0], 2)) else $error("slew not taken");
    chk_los_thr: assert property (wr_go && host_req.addr == 8'h19
        |=> {backup_los_threshold, main_los_threshold} == $past(host_req.wdata[3:0]))
        else $error("threshold not taken");
endmodule
bind smon_status_monitor smon_monitor u_mon (.*);
`default_nettype wire

/* File: tb/smon_nvm_model.sv */
// loader stand-in that answers the power-up copy request
`default_nettype none
module smon_nvm_model #(
    parameter int LATENCY = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nvm_load_req,
    output var smon_pkg::smon_req_t nvm_req,
    output logic nvm_load_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_ff;
    // copies nothing; rom is never rewritten
    assign nvm_req = '0;
    // done rises a fixed delay after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 0;
            nvm_load_done <= 1'b0;
        end else if (nvm_load_req) begin
            wait_ff <= LATENCY;
        end else if (wait_ff > 1) begin
            wait_ff <= wait_ff - 1;
        end else if (wait_ff == 1) begin
            nvm_load_done <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench of the status and interrupt monitor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    smon_pkg::smon_req_t host_req = '0;
    smon_pkg::smon_req_t nvm_req;
    smon_pkg::smon_ref_t mref = '0;
    logic [1:0] tick = 2'h0, slip = 2'h0, cal = 2'h0, sw = 2'h0;
    logic [5:0] div = 6'h00;
    logic [3:0] byp = 4'h0;
    logic [7:0] rdata;
    logic rvalid, ld_req, ld_done, pin_a, pin_b, irq, from_ee;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    always #20 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end
    smon_status_monitor #(.SLIPS(2), .RELOCK(4)) DUT (.clk(clk), .rst_n(rst_n),
        .host_req(host_req), .host_rdata(rdata), .host_rvalid(rvalid), .config_source_pin(1'b1),
        .nvm_load_req(ld_req), .nvm_from_eeprom(from_ee), .nvm_req(nvm_req), .nvm_load_done(ld_done),
        .main_reference(mref), .backup_reference(4'h0), .main_los_threshold(),
        .backup_los_threshold(), .pll_cmp_tick(tick), .pll_slip(slip), .pll_cal_active(cal),
        .pll_auto_switch(sw), .div_tick(div), .r_div_bypass(byp[1:0]), .m_div_bypass(byp[3:2]),
        .vital_pin_a(pin_a), .vital_pin_b(pin_b), .pin_slow_slew(), .combined_irq(irq));
    smon_nvm_model u_nvm (.clk(clk), .rst_n(rst_n), .nvm_load_req(ld_req),
        .nvm_req(nvm_req), .nvm_load_done(ld_done));
    ////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) host_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) host_req <= '0;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) host_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) host_req <= '0;
        #1 chk_bit(rvalid, 1'b1);
        chk_byte(rdata, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // writes during the copy are dropped
    task automatic t_startup();
        wait (ld_req === 1'b1);
        wr8(smon_pkg::ADR_SLEW_CTRL, 8'h03);
        wait (ld_done === 1'b1);
        @(posedge clk);
        chk_bit(from_ee, 1'b1);
        rd8(smon_pkg::ADR_SLEW_CTRL, 8'h00);
        rd8(smon_pkg::ADR_PIN_SEL_B, 8'h02);
        rd8(8'h20, 8'h00);
        wr8(smon_pkg::ADR_IRQ_CTRL, 8'hff);
        rd8(smon_pkg::ADR_IRQ_CTRL, 8'h03);
        wr8(smon_pkg::ADR_IRQ_CTRL, 8'h00);
        wr8(smon_pkg::ADR_SLEW_CTRL, 8'h02);
    endtask
    // all codes on pin a, main reference lost
    task automatic t_pins();
        @(posedge clk) mref <= 4'h4;
        for (int c = 0; c < 16; c++) begin
            wr8(smon_pkg::ADR_PIN_SEL_A, 8'(c));
            rd8(smon_pkg::ADR_PIN_SEL_A, 8'(c));
            chk_bit(pin_a, c == 0);
        end
        wr8(smon_pkg::ADR_PIN_SEL_A, 8'h00);
        wr8(smon_pkg::ADR_PIN_POL, 8'h01);
        @(posedge clk) mref <= 4'ha;
        wr8(smon_pkg::ADR_LOS_CFG, 8'h20);
        settle();
        chk_bit(pin_a, 1'b1);
        wr8(smon_pkg::ADR_LOS_CFG, 8'h10);
        settle();
        chk_bit(pin_a, 1'b0);
        wr8(smon_pkg::ADR_PIN_POL, 8'h00);
    endtask
    // the slip past the limit declares unlock
    task automatic t_lock();
        for (int i = 1; i <= 3; i++) begin
            @(posedge clk) {slip, tick} <= 4'h5;
            @(posedge clk) {slip, tick} <= 4'h0;
            settle();
            chk_bit(pin_b, i == 3);
        end
    endtask
    task automatic t_irq();
        wr8(smon_pkg::ADR_IRQ_CTRL, 8'h01);
        @(posedge clk) cal <= 2'h1;
        @(posedge clk) cal <= 2'h0;
        settle();
        chk_bit(irq, 1'b1);
        rd8(smon_pkg::ADR_LATCHED_IRQ, 8'h10);
        rd8(smon_pkg::ADR_LATCHED_IRQ, 8'h00);
        rd8(smon_pkg::ADR_LIVE_IRQ, 8'h15);
        rd8(smon_pkg::ADR_LIVE_IRQ, 8'h05);
        wr8(smon_pkg::ADR_IRQ_MASK, 8'hbf);
        @(posedge clk) cal <= 2'h1;
        settle();
        chk_bit(irq, 1'b0);
        wr8(smon_pkg::ADR_IRQ_MASK, 8'haf);
        wr8(smon_pkg::ADR_IRQ_CTRL, 8'h03);
        settle();
        chk_bit(irq, 1'b0);
        @(posedge clk) sw <= 2'h1;
        settle();
        chk_bit(irq, 1'b1);
        wr8(smon_pkg::ADR_IRQ_CTRL, 8'h00);
        settle();
        chk_bit(irq, 1'b0);
    endtask
    task automatic close_out();
        $display("errors %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_startup();
        t_pins();
        t_lock();
        t_irq();
        close_out();
    end
endmodule
`default_nettype wire
